//--- tcd_pkg.sv
// Package of constants and types for the tributary control command decoder
// ---------------------------------------------------------------------
// Summary of operation
// - Unlatch modifier bit, without latch, sends the addressed tributary to active polling.
// - After unlatch, automatic polling controls that tributary again.
// - Latch modifier bit forces polling state to parameter byte bits 1:0.
// - Latched field: 00 active, 01 inactive, 10 unresponsive, 11 dead.
// - Request key 00 is a null command: it creates no slot and returns register ownership.
// - Pool and polling modifier bits still act alongside the null key.
// - Request key 01 creates a status slot for the addressed tributary.
// - Twelve tributary slots, each sixty-four eight-bit locations.
// - Once any tributary is established, a single global slot exists.
// - Pool and polling modifier bits combine with establish as one command.
// - Enable adds parameter to quota; 377 in either sets unlimited, else a sum of 377 octal or more errors, caps 376.
// - Pool disable stops common pool use and clears the quota to zero.
// ---------------------------------------------------------------------
package tcd_pkg;

    // -----------------------------------------------------------------
    // Modifier byte bit positions (bits 8..15 of the command word)
    // -----------------------------------------------------------------
    localparam int MOD_POOL_EN_BIT  = 0;
    localparam int MOD_POOL_DIS_BIT = 1;
    localparam int MOD_UNLATCH_BIT  = 4;
    localparam int MOD_LATCH_BIT    = 5;

    // -----------------------------------------------------------------
    // Sizes, keys and reset values
    // -----------------------------------------------------------------
    localparam int NUM_SLOTS      = 12;
    localparam int SLOT_WORDS     = 64;
    localparam int SLOT_IDX_W     = 4;
    localparam int KEY_W          = 3;
    localparam logic [KEY_W-1:0] KEY_NULL      = 3'h0;
    localparam logic [KEY_W-1:0] KEY_ESTABLISH = 3'h1;
    localparam logic [7:0] QUOTA_UNLIMITED = 8'hff;
    localparam logic [7:0] QUOTA_CAP       = 8'hfe;
    localparam logic [7:0] QUOTA_RST       = 8'h00;
    localparam logic [7:0] ADDR_RST        = 8'h00;

    typedef enum logic [1:0] {
        TCD_POLL_ACTIVE   = 2'b00,
        TCD_POLL_INACTIVE = 2'b01,
        TCD_POLL_UNRESP   = 2'b10,
        TCD_POLL_DEAD     = 2'b11
    } tcd_poll_e;

    typedef enum logic [1:0] {
        TCD_ST_IDLE   = 2'b00,
        TCD_ST_LOOKUP = 2'b01,
        TCD_ST_APPLY  = 2'b10
    } tcd_state_e;

endpackage

//--- tcd_slot_if.sv
// Interface carrying slot table lookup and update between modules
interface tcd_slot_if;
    import tcd_pkg::*;
    logic [7:0]            addr;
    logic                  hit;
    logic [SLOT_IDX_W-1:0] hit_idx;
    logic                  free_ok;
    logic [SLOT_IDX_W-1:0] free_idx;
    logic                  alloc;
    logic [SLOT_IDX_W-1:0] alloc_idx;
    logic                  any_valid;

    modport ctrl (
        output addr,
        output alloc,
        output alloc_idx,
        input  hit,
        input  hit_idx,
        input  free_ok,
        input  free_idx,
        input  any_valid
    );
    modport table_side (
        input  addr,
        input  alloc,
        input  alloc_idx,
        output hit,
        output hit_idx,
        output free_ok,
        output free_idx,
        output any_valid
    );
endinterface

//--- tcd_slot_table.sv
// Tributary address table: one entry per status slot
module tcd_slot_table
    import tcd_pkg::*;
#(
    parameter int N = NUM_SLOTS
) (
    input  wire logic  mclk_i,
    input  wire logic  nrst_i,
    tcd_slot_if.table_side sl
);
    initial begin
        if (N < 1 || N > (1 << SLOT_IDX_W)) begin
            $error("Slot count out of range");
        end
    end

    logic [N-1:0] valid_ff;
    logic [7:0]   addr_ff [N];

    // -----------------------------------------------------------------
    // Entry storage
    // -----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_ent
            always_ff @(posedge mclk_i) begin
                if (!nrst_i) begin
                    valid_ff[g] <= 1'b0;
                    addr_ff[g]  <= ADDR_RST;
                end else if (sl.alloc && sl.alloc_idx == SLOT_IDX_W'(g)) begin
                    valid_ff[g] <= 1'b1;
                    addr_ff[g]  <= sl.addr;
                end
            end
        end
    endgenerate

    // -----------------------------------------------------------------
    // Search
    // -----------------------------------------------------------------
    always_comb begin
        sl.hit      = 1'b0;
        sl.hit_idx  = '0;
        sl.free_ok  = 1'b0;
        sl.free_idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (valid_ff[i] && addr_ff[i] == sl.addr) begin
                sl.hit     = 1'b1;
                sl.hit_idx = SLOT_IDX_W'(i);
            end
            if (!valid_ff[i]) begin
                sl.free_ok  = 1'b1;
                sl.free_idx = SLOT_IDX_W'(i);
            end
        end
    end

    assign sl.any_valid = |valid_ff;

endmodule // tcd_slot_table

//--- tcd_poll_ctrl.sv
// Per-slot polling state with latch, unlatch and automatic update
module tcd_poll_ctrl
    import tcd_pkg::*;
#(
    parameter int N = NUM_SLOTS
) (
    input  wire logic                  mclk_i,
    input  wire logic                  nrst_i,
    input  wire logic                  set_i,
    input  wire logic [SLOT_IDX_W-1:0] idx_i,
    input  wire logic                  latch_i,
    input  wire logic                  unlatch_i,
    input  wire logic [1:0]            val_i,
    input  wire logic                  auto_we_i,
    input  wire logic [SLOT_IDX_W-1:0] auto_idx_i,
    input  wire logic [1:0]            auto_val_i,
    output      logic [2*N-1:0]        state_o,
    output      logic [N-1:0]          latched_o
);
    initial begin
        if (N < 1 || N > (1 << SLOT_IDX_W)) begin
            $error("Slot count out of range");
        end
    end

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_poll
            logic mine;
            assign mine = set_i && idx_i == SLOT_IDX_W'(g);
            always_ff @(posedge mclk_i) begin
                if (!nrst_i) begin
                    state_o[2*g +: 2] <= TCD_POLL_ACTIVE;
                    latched_o[g]      <= 1'b0;
                end else if (mine && latch_i) begin
                    state_o[2*g +: 2] <= val_i;
                    latched_o[g]      <= 1'b1;
                end else if (mine && unlatch_i) begin
                    state_o[2*g +: 2] <= TCD_POLL_ACTIVE;
                    latched_o[g]      <= 1'b0;
                end else if (auto_we_i && !latched_o[g]
                             && auto_idx_i == SLOT_IDX_W'(g)) begin
                    state_o[2*g +: 2] <= auto_val_i;
                end
            end
        end
    endgenerate

endmodule // tcd_poll_ctrl

//--- tcd_decoder.sv
// Top: control command decoder for tributary management
module tcd_decoder
    import tcd_pkg::*;
#(
    parameter int N = NUM_SLOTS
) (
    input  wire logic                  mclk_i,
    input  wire logic                  nrst_i,
    input  wire logic                  cmd_valid_i,
    input  wire logic [KEY_W-1:0]      cmd_key_i,
    input  wire logic [7:0]            tributary_address_byte_i,
    input  wire logic [7:0]            command_parameter_byte_i,
    input  wire logic [7:0]            command_modifier_byte_i,
    input  wire logic                  auto_we_i,
    input  wire logic [SLOT_IDX_W-1:0] auto_idx_i,
    input  wire logic [1:0]            auto_val_i,
    input  wire logic                  pool_use_i,
    input  wire logic [SLOT_IDX_W-1:0] pool_use_idx_i,
    input  wire logic [SLOT_IDX_W-1:0] slot_rd_idx_i,
    input  wire logic [5:0]            slot_rd_loc_i,
    input  wire logic                  slot_we_i,
    input  wire logic [7:0]            slot_wdata_i,
    output      logic                  input_ready_flag_o,
    output      logic                  cmd_done_o,
    output      logic                  proc_err_o,
    output      logic                  global_status_slot_o,
    output      logic [N-1:0]          slot_valid_o,
    output      logic [2*N-1:0]        poll_state_o,
    output      logic [N-1:0]          poll_latched_o,
    output      logic [N-1:0]          pool_enabled_o,
    output      logic [8*N-1:0]        quota_o,
    output      logic [7:0]            slot_rdata_o
);
    default clocking cb_main @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);

    initial begin
        if (N < 1 || N > (1 << SLOT_IDX_W)) begin
            $error("Slot count out of range");
        end
    end

    tcd_slot_if sl ();

    tcd_state_e           state_ff;
    logic [KEY_W-1:0]     key_ff;
    logic [7:0]           addr_ff;
    logic [7:0]           parm_ff;
    logic                 pool_en_ff;
    logic                 pool_dis_ff;
    logic                 latch_ff;
    logic                 unlatch_ff;
    logic                 tgt_ok_ff;
    logic [SLOT_IDX_W-1:0] tgt_idx_ff;
    logic                 alloc_go;
    logic                 apply_go;
    logic [7:0]           mem_ff [N][SLOT_WORDS];
    logic [N-1:0]         valid_ff;

    // -----------------------------------------------------------------
    // Command capture; reserved modifier bits are dropped
    // -----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            key_ff      <= KEY_NULL;
            addr_ff     <= ADDR_RST;
            parm_ff     <= 8'h00;
            pool_en_ff  <= 1'b0;
            pool_dis_ff <= 1'b0;
            latch_ff    <= 1'b0;
            unlatch_ff  <= 1'b0;
        end else if (state_ff == TCD_ST_IDLE && cmd_valid_i) begin
            key_ff      <= cmd_key_i;
            addr_ff     <= tributary_address_byte_i;
            parm_ff     <= command_parameter_byte_i;
            pool_en_ff  <= command_modifier_byte_i[MOD_POOL_EN_BIT];
            pool_dis_ff <= command_modifier_byte_i[MOD_POOL_DIS_BIT];
            latch_ff    <= command_modifier_byte_i[MOD_LATCH_BIT];
            unlatch_ff  <= command_modifier_byte_i[MOD_UNLATCH_BIT];
        end
    end

    // -----------------------------------------------------------------
    // Sequencer
    // -----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            state_ff <= TCD_ST_IDLE;
        end else begin
            unique case (state_ff)
                TCD_ST_IDLE: begin
                    if (cmd_valid_i) begin
                        state_ff <= TCD_ST_LOOKUP;
                    end
                end
                TCD_ST_LOOKUP: begin
                    state_ff <= TCD_ST_APPLY;
                end
                TCD_ST_APPLY: begin
                    state_ff <= TCD_ST_IDLE;
                end
                default: begin
                    state_ff <= TCD_ST_IDLE;
                end
            endcase
        end
    end

    // Lookup resolves the target slot, allocating on establish
    assign sl.addr      = addr_ff;
    assign alloc_go     = state_ff == TCD_ST_LOOKUP
                          && key_ff == KEY_ESTABLISH
                          && !sl.hit && sl.free_ok;
    assign sl.alloc     = alloc_go;
    assign sl.alloc_idx = sl.free_idx;
    assign apply_go     = state_ff == TCD_ST_APPLY && tgt_ok_ff;

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            tgt_ok_ff  <= 1'b0;
            tgt_idx_ff <= '0;
        end else if (state_ff == TCD_ST_LOOKUP) begin
            tgt_ok_ff  <= sl.hit || alloc_go;
            tgt_idx_ff <= sl.hit ? sl.hit_idx : sl.free_idx;
        end
    end

    tcd_slot_table #(
        .N (N)
    ) u_table (
        .mclk_i (mclk_i),
        .nrst_i (nrst_i),
        .sl     (sl.table_side)
    );

    // -----------------------------------------------------------------
    // Polling state: modifiers act with any key
    // -----------------------------------------------------------------
    logic [2*N-1:0] poll_w;
    logic [N-1:0]   lat_w;

    tcd_poll_ctrl #(
        .N (N)
    ) u_poll (
        .mclk_i     (mclk_i),
        .nrst_i     (nrst_i),
        .set_i      (apply_go),
        .idx_i      (tgt_idx_ff),
        .latch_i    (latch_ff),
        .unlatch_i  (unlatch_ff),
        .val_i      (parm_ff[1:0]),
        .auto_we_i  (auto_we_i),
        .auto_idx_i (auto_idx_i),
        .auto_val_i (auto_val_i),
        .state_o    (poll_w),
        .latched_o  (lat_w)
    );

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            poll_state_o   <= '0;
            poll_latched_o <= '0;
        end else begin
            poll_state_o   <= poll_w;
            poll_latched_o <= lat_w;
        end
    end

    // -----------------------------------------------------------------
    // Common pool quota per slot
    // -----------------------------------------------------------------
    logic [N-1:0] err_vec;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_quota
            logic       mine;
            logic [8:0] sum;
            logic [7:0] q;
            assign q    = quota_o[8*g +: 8];
            assign mine = apply_go && tgt_idx_ff == SLOT_IDX_W'(g);
            assign sum  = {1'b0, q} + {1'b0, parm_ff};
            assign err_vec[g] = mine && pool_en_ff
                                && parm_ff != QUOTA_UNLIMITED
                                && q != QUOTA_UNLIMITED
                                && sum >= {1'b0, QUOTA_UNLIMITED};
            always_ff @(posedge mclk_i) begin
                if (!nrst_i) begin
                    quota_o[8*g +: 8] <= QUOTA_RST;
                    pool_enabled_o[g] <= 1'b0;
                end else if (mine && pool_dis_ff) begin
                    quota_o[8*g +: 8] <= QUOTA_RST;
                    pool_enabled_o[g] <= 1'b0;
                end else if (mine && pool_en_ff) begin
                    pool_enabled_o[g] <= 1'b1;
                    if (parm_ff == QUOTA_UNLIMITED
                        || q == QUOTA_UNLIMITED) begin
                        quota_o[8*g +: 8] <= QUOTA_UNLIMITED;
                    end else if (err_vec[g]) begin
                        quota_o[8*g +: 8] <= QUOTA_CAP;
                    end else begin
                        quota_o[8*g +: 8] <= sum[7:0];
                    end
                end else if (pool_use_i && pool_use_idx_i == SLOT_IDX_W'(g)
                             && pool_enabled_o[g] && q != QUOTA_RST
                             && q != QUOTA_UNLIMITED) begin
                    quota_o[8*g +: 8] <= q - 8'h01;
                end
            end
        end
    endgenerate

    // -----------------------------------------------------------------
    // Status slot storage, sixty-four bytes per slot
    // -----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (slot_we_i && valid_ff[slot_rd_idx_i]) begin
            mem_ff[slot_rd_idx_i][slot_rd_loc_i] <= slot_wdata_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            slot_rdata_o <= 8'h00;
        end else if (int'(slot_rd_idx_i) < N) begin
            slot_rdata_o <= mem_ff[slot_rd_idx_i][slot_rd_loc_i];
        end else begin
            slot_rdata_o <= 8'h00;
        end
    end

    // -----------------------------------------------------------------
    // Status outputs and register ownership
    // -----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            valid_ff <= '0;
        end else if (alloc_go) begin
            valid_ff[sl.free_idx] <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            input_ready_flag_o   <= 1'b1;
            cmd_done_o           <= 1'b0;
            proc_err_o           <= 1'b0;
            global_status_slot_o <= 1'b0;
            slot_valid_o         <= '0;
        end else begin
            // Ownership returns to host on any key, null included
            if (state_ff == TCD_ST_IDLE && cmd_valid_i) begin
                input_ready_flag_o <= 1'b0;
            end else if (state_ff == TCD_ST_APPLY) begin
                input_ready_flag_o <= 1'b1;
            end
            cmd_done_o <= state_ff == TCD_ST_APPLY;
            proc_err_o <= state_ff == TCD_ST_APPLY
                          && (|err_vec
                              || (key_ff == KEY_ESTABLISH && !tgt_ok_ff)
                              || (key_ff == KEY_NULL && !tgt_ok_ff
                                  && (pool_en_ff || pool_dis_ff
                                      || latch_ff || unlatch_ff)));
            global_status_slot_o <= sl.any_valid;
            slot_valid_o         <= valid_ff;
        end
    end

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    sequence s_accept;
        state_ff == TCD_ST_IDLE && cmd_valid_i;
    endsequence

    sequence s_owner_back;
        !input_ready_flag_o ##2 input_ready_flag_o;
    endsequence

    a_cmd_takes_three: assert property (s_accept |-> ##3 cmd_done_o)
        else $error("Command did not finish in three cycles");

    a_ready_returns: assert property (s_accept |-> ##1 s_owner_back)
        else $error("Input ready not returned after command");

    a_establish_alloc: assert property (alloc_go |=> sl.hit)
        else $error("Established address not found in table");

    a_gss_follows: assert property (
        alloc_go |-> ##2 global_status_slot_o)
        else $error("Global slot missing after establish");

    a_unlatch_active: assert property (
        apply_go && unlatch_ff && !latch_ff
        |=> poll_w[2*tgt_idx_ff +: 2] == TCD_POLL_ACTIVE
            && !lat_w[tgt_idx_ff])
        else $error("Unlatch did not select active state");

    a_latch_value: assert property (
        apply_go && latch_ff
        |=> poll_w[2*$past(tgt_idx_ff) +: 2] == $past(parm_ff[1:0]))
        else $error("Latched state differs from parameter");

    a_disable_clears: assert property (
        apply_go && pool_dis_ff
        |=> quota_o[8*$past(tgt_idx_ff) +: 8] == QUOTA_RST)
        else $error("Pool disable left quota nonzero");

    a_quota_cap: assert property (
        |err_vec && !pool_dis_ff
        |=> quota_o[8*$past(tgt_idx_ff) +: 8] == QUOTA_CAP && proc_err_o)
        else $error("Quota overflow not capped with error");

endmodule // tcd_decoder

//--- tcd_host_model.sv
// Host program model that issues control commands to the decoder
module tcd_host_model
    import tcd_pkg::*;
(
    input  wire logic             mclk_i,
    input  wire logic             rdy_i,
    input  wire logic             done_i,
    output      logic             valid_o,
    output      logic [KEY_W-1:0] key_o,
    output      logic [7:0]       addr_o,
    output      logic [7:0]       par_o,
    output      logic [7:0]       mod_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        valid_o = 1'b0;
        key_o   = KEY_NULL;
        addr_o  = 8'h00;
        par_o   = 8'h00;
        mod_o   = 8'h00;
    end

    // Wait for ownership, strobe one command, wait for its completion
    task automatic issue(input logic [KEY_W-1:0] k, input logic [7:0] a,
                         input logic [7:0] p, input logic [7:0] m,
                         input logic dirty, output logic ok);
        int n;
        ok = 1'b0;
        for (n = 0; n < 50 && rdy_i !== 1'b1; n++) @(negedge mclk_i);
        if (rdy_i !== 1'b1) begin
            return;
        end
        @(posedge mclk_i);
        valid_o <= 1'b1;
        key_o   <= k;
        addr_o  <= a;
        par_o   <= p;
        mod_o   <= dirty ? m : (m & 8'h33);
        @(posedge mclk_i);
        // Released lines do not hold the last value
        valid_o <= 1'b0;
        key_o   <= ~k;
        addr_o  <= ~a;
        par_o   <= ~p;
        mod_o   <= ~m;
        for (n = 0; n < 20; n++) begin
            @(negedge mclk_i);
            if (done_i === 1'b1) begin
                ok = 1'b1;
                break;
            end
        end
        @(negedge mclk_i);
    endtask
endmodule // tcd_host_model

//--- tcd_decoder_tb_top.sv
// Self-checking testbench of the tributary control command decoder
module tcd_decoder_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import tcd_pkg::*;
    localparam int N = NUM_SLOTS;
    localparam logic [7:0] PP [4] = '{8'h10, 8'hf0, 8'h00, 8'hff};
    localparam logic [7:0] PM [4] = '{8'h01, 8'h01, 8'h03, 8'h01};
    localparam logic [7:0] PQ [4] = '{8'h10, 8'hfe, 8'h00, 8'hff};
    localparam logic [7:0] PD [4] = '{8'h0f, 8'hfd, 8'h00, 8'hff};
    logic                  mclk_i = 1'b0, nrst_i = 1'b0, cmd_valid_i;
    logic [KEY_W-1:0]      cmd_key_i;
    logic [7:0]            tributary_address_byte_i, command_parameter_byte_i;
    logic [7:0]            command_modifier_byte_i, slot_wdata_i = 8'h00;
    logic                  auto_we_i = 1'b0, pool_use_i = 1'b0;
    logic                  slot_we_i = 1'b0, ok;
    logic [1:0]            auto_val_i = 2'b00;
    logic [SLOT_IDX_W-1:0] auto_idx_i = '0, pool_use_idx_i = '0;
    logic [SLOT_IDX_W-1:0] slot_rd_idx_i = '0;
    logic [5:0]            slot_rd_loc_i = 6'h00;
    logic                  input_ready_flag_o, cmd_done_o, proc_err_o;
    logic                  global_status_slot_o;
    logic [N-1:0]          slot_valid_o, poll_latched_o, pool_enabled_o;
    logic [2*N-1:0]        poll_state_o;
    logic [8*N-1:0]        quota_o;
    logic [7:0]            slot_rdata_o, p, a;
    logic [4:0]            nt;
    logic [4:0]            exp_q [$];
    int                    mismatches = 0, check_count = 0, ix1, ix2;

    always #2.5 mclk_i = ~mclk_i;

    tcd_decoder #(.N(N)) u_tcd_decoder (.mclk_i, .nrst_i, .cmd_valid_i,
        .cmd_key_i, .tributary_address_byte_i, .command_parameter_byte_i,
        .command_modifier_byte_i, .auto_we_i, .auto_idx_i, .auto_val_i,
        .pool_use_i, .pool_use_idx_i, .slot_rd_idx_i, .slot_rd_loc_i,
        .slot_we_i, .slot_wdata_i, .input_ready_flag_o, .cmd_done_o,
        .proc_err_o, .global_status_slot_o, .slot_valid_o, .poll_state_o,
        .poll_latched_o, .pool_enabled_o, .quota_o, .slot_rdata_o);

    tcd_host_model u_tcd_host_model (.mclk_i, .rdy_i(input_ready_flag_o),
        .done_i(cmd_done_o), .valid_o(cmd_valid_i), .key_o(cmd_key_i),
        .addr_o(tributary_address_byte_i), .par_o(command_parameter_byte_i),
        .mod_o(command_modifier_byte_i));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Note the expected outcome, then let the host issue the command
    task automatic cmd(input logic [KEY_W-1:0] k, input logic [7:0] ca, cp,
                       input logic [7:0] cm, input logic e,
                       input logic [3:0] nv, input logic d = 1'b0);
        exp_q.push_back({e, nv});
        u_tcd_host_model.issue(k, ca, cp, cm, d, ok);
        if (ok !== 1'b1) begin
            mismatches++;
            close_out();
        end
    endtask

    always @(negedge mclk_i) begin
        if (cmd_done_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk(32'h1, 32'h0);
            end else begin
                nt = exp_q.pop_front();
                chk(proc_err_o, nt[4]);
                chk($countones(slot_valid_o), nt[3:0]);
                chk(global_status_slot_o, nt[3:0] != 4'h0);
            end
        end
    end

    initial begin
        void'($urandom(32'hdc243a44));
        repeat (19) @(negedge mclk_i);
        chk(input_ready_flag_o, 1'b1);
        chk(|{cmd_done_o, proc_err_o, global_status_slot_o}, 0);
        chk(|{slot_valid_o, poll_state_o, poll_latched_o}, 0);
        chk(|{pool_enabled_o, quota_o}, 0);
        @(posedge mclk_i);
        nrst_i <= 1'b1;
        $display("test reset done");
        cmd(KEY_ESTABLISH, 8'h01, 8'h00, 8'h00, 1'b0, 4'd1);
        for (int i = 0; i < N; i++) begin
            if (slot_valid_o[i] === 1'b1) ix1 = i;
        end
        for (int s = 0; s < 4; s++) begin
            p = $urandom();
            p[1:0] = 2'(s);
            cmd(s[0] ? KEY_ESTABLISH : KEY_NULL, 8'h01, p, 8'hec, 1'b0,
                4'd1, 1'b1);
            chk(poll_state_o[2*ix1+:2], s);
            chk(poll_latched_o[ix1], 1'b1);
        end
        $display("test latch done");
        @(posedge mclk_i);
        auto_we_i  <= 1'b1;
        auto_idx_i <= 4'(ix1);
        auto_val_i <= 2'b01;
        repeat (3) @(negedge mclk_i);
        chk(poll_state_o[2*ix1+:2], 2'b11);
        @(posedge mclk_i);
        auto_we_i <= 1'b0;
        cmd(KEY_NULL, 8'h01, 8'h03, 8'h10, 1'b0, 4'd1);
        chk(poll_state_o[2*ix1+:2], 2'b00);
        chk(poll_latched_o[ix1], 1'b0);
        @(posedge mclk_i);
        auto_we_i <= 1'b1;
        repeat (3) @(negedge mclk_i);
        chk(poll_state_o[2*ix1+:2], 2'b01);
        @(posedge mclk_i);
        auto_we_i <= 1'b0;
        $display("test auto done");
        for (int i = 0; i < 4; i++) begin
            cmd(KEY_NULL, 8'h01, PP[i], PM[i], i == 1, 4'd1);
            chk(quota_o[8*ix1+:8], PQ[i]);
            chk(pool_enabled_o[ix1], i != 2);
            @(posedge mclk_i);
            pool_use_i     <= 1'b1;
            pool_use_idx_i <= 4'(ix1);
            @(posedge mclk_i);
            pool_use_i <= 1'b0;
            repeat (2) @(negedge mclk_i);
            chk(quota_o[8*ix1+:8], PD[i]);
        end
        $display("test pool done");
        cmd(KEY_ESTABLISH, 8'h02, 8'h22, 8'h21, 1'b0, 4'd2);
        for (int i = 0; i < N; i++) begin
            if (slot_valid_o[i] === 1'b1 && i != ix1) ix2 = i;
        end
        chk(poll_state_o[2*ix2+:2], 2'b10);
        chk({poll_latched_o[ix2], pool_enabled_o[ix2]}, 2'b11);
        chk(quota_o[8*ix2+:8], 8'h22);
        $display("test establish done");
        for (int i = 0; i < N - 2; i++) begin
            a = {2'b01, 4'(i), 2'($urandom())};
            cmd(KEY_ESTABLISH, a, 8'h00, 8'h00, 1'b0, 4'(i + 3));
        end
        cmd(KEY_ESTABLISH, 8'h80, 8'h00, 8'h00, 1'b1, 4'd12);
        cmd(KEY_NULL, 8'h81, 8'h05, 8'h01, 1'b1, 4'd12);
        cmd(KEY_NULL, 8'h01, 8'h00, 8'h00, 1'b0, 4'd12);
        $display("test fill done");
        p = $urandom();
        @(posedge mclk_i);
        slot_rd_idx_i <= 4'(ix1);
        slot_rd_loc_i <= 6'h3f;
        slot_wdata_i  <= p;
        slot_we_i     <= 1'b1;
        @(posedge mclk_i);
        slot_we_i <= 1'b0;
        repeat (2) @(negedge mclk_i);
        chk(slot_rdata_o, p);
        $display("test memory done");
        close_out();
    end
endmodule // tcd_decoder_tb_top
